// [inc/tsde_pkg.sv]
`default_nettype none
package tsde_pkg;
  localparam int unsigned CLK_FREQ_HZ = 40_000_000;
  localparam int unsigned BLINK_HALF_PERIOD_MS = 500;
  localparam int unsigned BLINK_HALF_CYCLES = CLK_FREQ_HZ / 1000 * BLINK_HALF_PERIOD_MS;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] DISPLAY_OFFSET = 8'h08;
  localparam int CTRL_HEX_BIT = 0;
  localparam int CTRL_OUTWORD_BIT = 1;
  localparam int CTRL_SRC_LSB = 2;
  localparam logic [31:0] CTRL_MASK = 32'h0000000f;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    TSDE_SRC_TERMINAL = 2'h0,
    TSDE_SRC_LINK = 2'h1,
    TSDE_SRC_CARD = 2'h2
  } tsde_src_t;

  localparam int IN_FORWARD_BIT = 0;
  localparam int IN_REVERSE_BIT = 1;
  localparam int IN_GEN_LSB = 2;
  localparam int IN_LINK_FORWARD_BIT = 13;
  localparam int IN_LINK_REVERSE_BIT = 14;
  localparam int IN_RST_BIT = 15;
  localparam int OUT_TR_LSB = 0;
  localparam int OUT_RELAY_BIT = 8;

  localparam int SEG_A = 0;
  localparam int SEG_B = 1;
  localparam int SEG_F = 5;
  localparam int SEG_G = 6;
  localparam int SEG_DP = 7;

  // bit 0 is segment a, bit 6 segment g, bit 7 the decimal point
  function automatic logic [7:0] hex_to_seg(input logic [3:0] v);
    logic [7:0] s;
    s = 8'h00;
    case (v)
      4'h0: s = 8'h3f;
      4'h1: s = 8'h06;
      4'h2: s = 8'h5b;
      4'h3: s = 8'h4f;
      4'h4: s = 8'h66;
      4'h5: s = 8'h6d;
      4'h6: s = 8'h7d;
      4'h7: s = 8'h07;
      4'h8: s = 8'h7f;
      4'h9: s = 8'h6f;
      4'ha: s = 8'h77;
      4'hb: s = 8'h7c;
      4'hc: s = 8'h39;
      4'hd: s = 8'h5e;
      4'he: s = 8'h79;
      default: s = 8'h71;
    endcase
    return s;
  endfunction
endpackage
`default_nettype wire

// [inc/tsde_blink_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface tsde_blink_if;
  logic phase;
  modport source (output phase);
  modport sink (input phase);
endinterface
`default_nettype wire

// [hw/tsde_blink_div.sv]
`timescale 1ns/10ps
`default_nettype none
module tsde_blink_div #(
  parameter int unsigned HALF_CYCLES = tsde_pkg::BLINK_HALF_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  tsde_blink_if.source blink
);
  if (HALF_CYCLES < 1) begin : g_bad_half_cycles
    $error("half period must be at least one cycle");
  end
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic phase_reg;
  logic phase_next;

  always_comb begin
    cnt_next = cnt_reg + 32'h00000001;
    phase_next = phase_reg;
    if (cnt_reg >= HALF_CYCLES - 1) begin
      cnt_next = 32'h00000000;
      phase_next = ~phase_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 32'h00000000;
      phase_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign blink.phase = phase_reg;
endmodule // tsde_blink_div
`default_nettype wire

// [hw/tsde_digit_drive.sv]
`timescale 1ns/10ps
`default_nettype none
module tsde_digit_drive (
  input wire logic [7:0] seg_in,
  input wire logic [3:0] nibble_in,
  input wire logic hex_mode_in,
  input wire logic blank_in,
  tsde_blink_if.sink blink,
  output logic [7:0] pattern_out
);
  always_comb begin
    if (hex_mode_in) begin
      pattern_out = tsde_pkg::hex_to_seg(nibble_in);
    end else if (blank_in) begin
      pattern_out = 8'h00;
      pattern_out[tsde_pkg::SEG_G] = blink.phase;
    end else begin
      pattern_out = seg_in;
    end
  end
endmodule // tsde_digit_drive
`default_nettype wire

// [hw/tsde_top.sv]
// Overview of operation
// - lowest digit segments a..g follow forward, reverse, general inputs 1..5.
// - third digit segments a, b follow transistor outputs 1 and 2.
// - fourth digit segment a follows the relay contact.
// - segment format with all inputs off blinks segment g on every digit, except under card source.
// - second digit f, g, dp show link forward, reverse, fault-reset commands.
// - hex format packs a 16-bit word, unused bits zero, four hex digits.
// - input word: forward bit 0, reverse bit 1, general inputs bits 2..6.
// - output word: transistor outputs 1 and 2 at bits 0 and 1.
// - output word: relay contact at bit 8.
// - link control shows command word plus command bits, non-inverted.
// - card mode maps card inputs and outputs onto digits and words.
`timescale 1ns/10ps
`default_nettype none
module tsde_top #(
  parameter int unsigned BLINK_HALF_CYCLES = tsde_pkg::BLINK_HALF_CYCLES
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic FORWARD_RUN_INPUT_IN,
  input wire logic REVERSE_RUN_INPUT_IN,
  input wire logic [4:0] GENERAL_INPUT_IN,
  input wire logic [1:0] TRANSISTOR_OUTPUT_IN,
  input wire logic RELAY_CONTACT_IN,
  input wire logic [15:0] LINK_COMMAND_WORD_IN,
  input wire logic LINK_FORWARD_COMMAND_IN,
  input wire logic LINK_REVERSE_COMMAND_IN,
  input wire logic LINK_FAULT_RESET_IN,
  input wire logic [12:0] CARD_INPUT_IN,
  input wire logic [7:0] CARD_OUTPUT_IN,
  output logic [31:0] DIGIT_SEG_OUT
);
  if (BLINK_HALF_CYCLES < 1) begin : g_bad_blink_half
    $error("blink half period must be at least one cycle");
  end

  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic ready_reg;
  logic [15:0] in_word_reg;
  logic [15:0] out_word_reg;
  logic [31:0] disp_reg;
  logic [31:0] disp_next;
  logic accept;

  logic [15:0] in_word;
  logic [15:0] out_word;
  logic [15:0] hex_word;
  logic [31:0] seg_raw;
  logic hex_mode;
  logic blank;
  tsde_pkg::tsde_src_t src;

  tsde_blink_if blink_bus ();

  tsde_blink_div #(
    .HALF_CYCLES(BLINK_HALF_CYCLES)
  ) u_blink (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .blink(blink_bus.source)
  );

  // display composition
  always_comb begin
    src = tsde_pkg::tsde_src_t'(ctrl_reg[tsde_pkg::CTRL_SRC_LSB +: 2]);
    hex_mode = ctrl_reg[tsde_pkg::CTRL_HEX_BIT];
    in_word = 16'h0000;
    out_word = 16'h0000;
    seg_raw = 32'h00000000;
    case (src)
      tsde_pkg::TSDE_SRC_CARD: begin
        in_word[12:0] = CARD_INPUT_IN;
        out_word[7:0] = CARD_OUTPUT_IN;
        seg_raw[7:0] = CARD_INPUT_IN[7:0];
        seg_raw[12:8] = CARD_INPUT_IN[12:8];
        seg_raw[23:16] = CARD_OUTPUT_IN;
      end
      tsde_pkg::TSDE_SRC_LINK: begin
        // link bits are shown as received, never inverted
        in_word = LINK_COMMAND_WORD_IN;
        in_word[tsde_pkg::IN_LINK_FORWARD_BIT] = LINK_FORWARD_COMMAND_IN;
        in_word[tsde_pkg::IN_LINK_REVERSE_BIT] = LINK_REVERSE_COMMAND_IN;
        in_word[tsde_pkg::IN_RST_BIT] = LINK_FAULT_RESET_IN;
        seg_raw[6:0] = in_word[6:0];
        seg_raw[8 + tsde_pkg::SEG_F] = LINK_FORWARD_COMMAND_IN;
        seg_raw[8 + tsde_pkg::SEG_G] = LINK_REVERSE_COMMAND_IN;
        seg_raw[8 + tsde_pkg::SEG_DP] = LINK_FAULT_RESET_IN;
      end
      default: begin
        in_word[tsde_pkg::IN_FORWARD_BIT] = FORWARD_RUN_INPUT_IN;
        in_word[tsde_pkg::IN_REVERSE_BIT] = REVERSE_RUN_INPUT_IN;
        in_word[tsde_pkg::IN_GEN_LSB +: 5] = GENERAL_INPUT_IN;
        seg_raw[6:0] = in_word[6:0];
      end
    endcase
    if (src != tsde_pkg::TSDE_SRC_CARD) begin
      out_word[tsde_pkg::OUT_TR_LSB +: 2] = TRANSISTOR_OUTPUT_IN;
      out_word[tsde_pkg::OUT_RELAY_BIT] = RELAY_CONTACT_IN;
      seg_raw[16 + tsde_pkg::SEG_A] = TRANSISTOR_OUTPUT_IN[0];
      seg_raw[16 + tsde_pkg::SEG_B] = TRANSISTOR_OUTPUT_IN[1];
      seg_raw[24 + tsde_pkg::SEG_A] = RELAY_CONTACT_IN;
    end
    // the card has no idle indication of its own, so it never blinks
    blank = !hex_mode && src != tsde_pkg::TSDE_SRC_CARD && in_word == 16'h0000;
    hex_word = ctrl_reg[tsde_pkg::CTRL_OUTWORD_BIT] ? out_word : in_word;
  end

  generate
    for (genvar d = 0; d < 4; d++) begin : g_digit
      tsde_digit_drive u_drive (
        .seg_in(seg_raw[8 * d +: 8]),
        .nibble_in(hex_word[4 * d +: 4]),
        .hex_mode_in(hex_mode),
        .blank_in(blank),
        .blink(blink_bus.sink),
        .pattern_out(disp_next[8 * d +: 8])
      );
    end
  endgenerate

  // bus slave: zero wait states; reads see a write in its data phase
  always_comb begin
    accept = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    wr_pend_next = accept && HWRITE_IN;
    addr_next = accept ? HADDR_IN[7:0] : addr_reg;
    ctrl_next = ctrl_reg;
    if (wr_pend_reg && addr_reg == tsde_pkg::CTRL_OFFSET) begin
      ctrl_next = HWDATA_IN & tsde_pkg::CTRL_MASK;
    end
    hrdata_next = hrdata_reg;
    if (accept && !HWRITE_IN) begin
      case (HADDR_IN[7:0])
        tsde_pkg::CTRL_OFFSET: hrdata_next = ctrl_next;
        tsde_pkg::STATUS_OFFSET: hrdata_next = {out_word_reg, in_word_reg};
        tsde_pkg::DISPLAY_OFFSET: hrdata_next = disp_reg;
        default: hrdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      ctrl_reg <= tsde_pkg::CTRL_RESET;
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      ready_reg <= 1'b1;
      in_word_reg <= 16'h0000;
      out_word_reg <= 16'h0000;
      disp_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      hrdata_reg <= hrdata_next;
      ready_reg <= 1'b1;
      in_word_reg <= in_word;
      out_word_reg <= out_word;
      disp_reg <= disp_next;
    end
  end

  assign HRDATA_OUT = hrdata_reg;
  assign HREADYOUT_OUT = ready_reg;
  assign HRESP_OUT = 1'b0;
  assign DIGIT_SEG_OUT = disp_reg;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  logic seg_term;
  assign seg_term = !hex_mode && src == tsde_pkg::TSDE_SRC_TERMINAL;

  AST_SEG_INPUTS: assert property (seg_term && !blank |=>
    DIGIT_SEG_OUT[6:0] == $past({GENERAL_INPUT_IN, REVERSE_RUN_INPUT_IN, FORWARD_RUN_INPUT_IN}))
    else $error("lowest digit does not follow input terminals");
  AST_SEG_TRANSISTOR: assert property (seg_term && !blank |=>
    DIGIT_SEG_OUT[17:16] == $past(TRANSISTOR_OUTPUT_IN))
    else $error("third digit does not follow transistor outputs");
  AST_SEG_RELAY: assert property (seg_term && !blank |=>
    DIGIT_SEG_OUT[24] == $past(RELAY_CONTACT_IN) && DIGIT_SEG_OUT[31:25] == 7'h00)
    else $error("fourth digit does not follow relay contact");
  AST_BLANK_BLINK: assert property (blank |=>
    DIGIT_SEG_OUT == {4{1'b0, $past(blink_bus.phase), 6'h00}})
    else $error("idle blink pattern wrong");
  AST_SEG_LINK_CMD: assert property (!hex_mode && src == tsde_pkg::TSDE_SRC_LINK && !blank |=>
    DIGIT_SEG_OUT[15:13] == $past({LINK_FAULT_RESET_IN, LINK_REVERSE_COMMAND_IN, LINK_FORWARD_COMMAND_IN}))
    else $error("second digit does not show link commands");
  AST_HEX_DIGITS: assert property (hex_mode |=>
    DIGIT_SEG_OUT[31:24] == tsde_pkg::hex_to_seg($past(hex_word[15:12]))
    && DIGIT_SEG_OUT[7:0] == tsde_pkg::hex_to_seg($past(hex_word[3:0])))
    else $error("hex digit order wrong");
  AST_HEX_UNUSED_ZERO: assert property (src == tsde_pkg::TSDE_SRC_TERMINAL |->
    in_word[15:7] == 9'h000 && out_word[15:9] == 7'h00 && out_word[7:2] == 6'h00)
    else $error("unassigned word bits not zero");
  AST_IN_WORD: assert property (src == tsde_pkg::TSDE_SRC_TERMINAL |=>
    in_word_reg[6:0] == $past({GENERAL_INPUT_IN, REVERSE_RUN_INPUT_IN, FORWARD_RUN_INPUT_IN}))
    else $error("input word packing wrong");
  AST_OUT_WORD: assert property (src != tsde_pkg::TSDE_SRC_CARD |=>
    out_word_reg[1:0] == $past(TRANSISTOR_OUTPUT_IN))
    else $error("transistor bits wrong");
  AST_OUT_RELAY: assert property (src != tsde_pkg::TSDE_SRC_CARD |=>
    out_word_reg[8] == $past(RELAY_CONTACT_IN))
    else $error("relay bit wrong");
  AST_LINK_WORD: assert property (src == tsde_pkg::TSDE_SRC_LINK |=>
    in_word_reg == $past({LINK_FAULT_RESET_IN, LINK_REVERSE_COMMAND_IN, LINK_FORWARD_COMMAND_IN,
    LINK_COMMAND_WORD_IN[12:0]}))
    else $error("link word wrong");
  AST_CARD_WORD: assert property (src == tsde_pkg::TSDE_SRC_CARD |=>
    in_word_reg == {3'h0, $past(CARD_INPUT_IN)} && out_word_reg == {8'h00, $past(CARD_OUTPUT_IN)})
    else $error("card words wrong");

  sequence ctrl_write_s;
    accept && HWRITE_IN && HADDR_IN[7:0] == tsde_pkg::CTRL_OFFSET ##1 1'b1;
  endsequence
  AST_CTRL_WRITE: assert property (ctrl_write_s |=>
    ctrl_reg == ($past(HWDATA_IN) & tsde_pkg::CTRL_MASK))
    else $error("control write lost");

  // cycles that the blink phase has held, for the half-period checks
  logic phase_prev_reg;
  logic phase_prev_next;
  logic [31:0] phase_held_reg;
  logic [31:0] phase_held_next;

  always_comb begin
    phase_prev_next = blink_bus.phase;
    phase_held_next = phase_held_reg + 32'h00000001;
    if (blink_bus.phase != phase_prev_reg) begin
      phase_held_next = 32'h00000001;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      phase_prev_reg <= 1'b0;
      phase_held_reg <= 32'h00000000;
    end else begin
      phase_prev_reg <= phase_prev_next;
      phase_held_reg <= phase_held_next;
    end
  end

  sequence link_seg_s;
    !hex_mode && src == tsde_pkg::TSDE_SRC_LINK && !blank;
  endsequence

  sequence card_seg_s;
    !hex_mode && src == tsde_pkg::TSDE_SRC_CARD;
  endsequence

  AST_SEG_DIGIT1_DARK: assert property (seg_term && !blank |=>
    DIGIT_SEG_OUT[15:8] == 8'h00)
    else $error("second digit lit without link commands");
  AST_SEG_DP_DARK: assert property (seg_term && !blank |=>
    DIGIT_SEG_OUT[7] == 1'b0)
    else $error("lowest digit point lit");
  AST_LINK_SEG_INPUTS: assert property (link_seg_s |=>
    DIGIT_SEG_OUT[6:0] == $past(LINK_COMMAND_WORD_IN[6:0]))
    else $error("lowest digit does not follow link word");
  AST_LINK_SEG_OUTPUTS: assert property (link_seg_s |=>
    DIGIT_SEG_OUT[17:16] == $past(TRANSISTOR_OUTPUT_IN) && DIGIT_SEG_OUT[24] == $past(RELAY_CONTACT_IN))
    else $error("outputs not shown under link control");
  AST_CARD_SEG: assert property (card_seg_s |=>
    DIGIT_SEG_OUT == {8'h00, $past(CARD_OUTPUT_IN), 3'h0, $past(CARD_INPUT_IN)})
    else $error("card segment map wrong");
  AST_CARD_UNUSED_ZERO: assert property (src == tsde_pkg::TSDE_SRC_CARD |->
    in_word[15:13] == 3'h0 && out_word[15:8] == 8'h00)
    else $error("card word upper bits not zero");
  AST_HEX_LIT: assert property (hex_mode |=>
    DIGIT_SEG_OUT[7:0] != 8'h00 && DIGIT_SEG_OUT[31:24] != 8'h00)
    else $error("hex digit dark or blinking");
  AST_HEX_MIDDLE: assert property (hex_mode |=>
    DIGIT_SEG_OUT[23:16] == tsde_pkg::hex_to_seg($past(hex_word[11:8]))
    && DIGIT_SEG_OUT[15:8] == tsde_pkg::hex_to_seg($past(hex_word[7:4])))
    else $error("middle hex digits wrong");
  AST_BLINK_HALF_PERIOD: assert property (blink_bus.phase != phase_prev_reg |->
    phase_held_reg == BLINK_HALF_CYCLES)
    else $error("blink half period wrong");
  AST_BLINK_BOUNDED: assert property (phase_held_reg <= BLINK_HALF_CYCLES)
    else $error("blink phase held too long");
endmodule // tsde_top
`default_nettype wire

// [testbench/tsde_far_side.sv]
`timescale 1ns/10ps
`default_nettype none
// terminal circuits and display of the drive; a closed contact reads high at the encoder
module tsde_far_side (
  input wire logic [9:0] closed_in,
  input wire logic [31:0] seg_in,
  output logic forward_out,
  output logic reverse_out,
  output logic [4:0] gen_out,
  output logic [1:0] tr_out,
  output logic relay_out,
  output logic [3:0] digit_lit_out
);
  assign forward_out = closed_in[0];
  assign reverse_out = closed_in[1];
  assign gen_out = closed_in[6:2];
  assign tr_out = closed_in[8:7];
  assign relay_out = closed_in[9];
  // a digit counts as lit when any of its segments is on
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      digit_lit_out[k] = |seg_in[8*k +: 8];
    end
  end
endmodule // tsde_far_side
`default_nettype wire

// [testbench/terminal_status_display_encoder_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module terminal_status_display_encoder_tb_top;
  localparam int HALF = 4;
  logic clk, rst_n, hsel, hwrite, lfwd, lrev, lrst, hready, hresp, forward, reverse, relay;
  logic [1:0] htrans, tr;
  logic [4:0] gen;
  logic [3:0] lit;
  logic [9:0] closed;
  logic [15:0] lword;
  logic [12:0] cin;
  logic [7:0] cout;
  logic [31:0] haddr, hwdata, hrdata, seg, q;
  int failures, n_compared;
  logic [7:0] seg_tab [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
                               8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};

  tsde_top #(.BLINK_HALF_CYCLES(HALF)) dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .FORWARD_RUN_INPUT_IN(forward), .REVERSE_RUN_INPUT_IN(reverse), .GENERAL_INPUT_IN(gen),
    .TRANSISTOR_OUTPUT_IN(tr), .RELAY_CONTACT_IN(relay), .LINK_COMMAND_WORD_IN(lword),
    .LINK_FORWARD_COMMAND_IN(lfwd), .LINK_REVERSE_COMMAND_IN(lrev), .LINK_FAULT_RESET_IN(lrst),
    .CARD_INPUT_IN(cin), .CARD_OUTPUT_IN(cout), .DIGIT_SEG_OUT(seg));
  tsde_far_side far (.closed_in(closed), .seg_in(seg), .forward_out(forward), .reverse_out(reverse),
    .gen_out(gen), .tr_out(tr), .relay_out(relay), .digit_lit_out(lit));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] hex_exp(input logic [15:0] w);
    return {seg_tab[w[15:12]], seg_tab[w[11:8]], seg_tab[w[7:4]], seg_tab[w[3:0]]};
  endfunction

  task automatic report_and_stop;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bounded wait for hready at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      failures++;
      report_and_stop;
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    q = hrdata;
    check("bus response", 32'h0, {31'h0, hresp});
  endtask

  // program the format, set all far-side states, then compare the display and its readback
  task automatic show(input string name, input logic [3:0] ctrl, input logic [9:0] c,
                      input logic [15:0] w, input logic [2:0] cmd, input logic [12:0] ci,
                      input logic [7:0] co, input logic [31:0] exp);
    ahb(1'b1, 32'h0, {28'h0, ctrl});
    @(posedge clk);
    closed <= c;
    lword <= w;
    {lrst, lrev, lfwd} <= cmd;
    cin <= ci;
    cout <= co;
    repeat (3) @(posedge clk);
    #1;
    check(name, exp, seg);
    ahb(1'b0, 32'h8, 32'h0);
    check({name, " readback"}, exp, q);
  endtask

  initial begin
    int on;
    {rst_n, hsel, hwrite, lfwd, lrev, lrst, htrans, closed, lword, cin, cout, haddr, hwdata} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("display after reset", 32'h0, seg);
    ahb(1'b0, 32'h0, 32'h0);
    check("control after reset", 32'h0, q);
    for (int i = 0; i < 7; i++) begin
      show("input segment", 4'h0, 10'h1 << i, 16'h0, 3'h0, 13'h0, 8'h0, 32'h1 << i);
    end
    show("output segments", 4'h0, 10'h385, 16'h0, 3'h0, 13'h0, 8'h0, 32'h01030005);
    ahb(1'b0, 32'h4, 32'h0);
    check("status words", 32'h01030005, q);
    show("source three", 4'hc, 10'h385, 16'h0, 3'h0, 13'h0, 8'h0, 32'h01030005);
    show("hex input", 4'h1, 10'h385, 16'h0, 3'h0, 13'h0, 8'h0, hex_exp(16'h0005));
    show("hex output", 4'h3, 10'h385, 16'h0, 3'h0, 13'h0, 8'h0, hex_exp(16'h0103));
    show("hex all inputs", 4'h1, 10'h07f, 16'h0, 3'h0, 13'h0, 8'h0, hex_exp(16'h007f));
    show("link segments", 4'h4, 10'h180, 16'h0055, 3'h7, 13'h0, 8'h0, 32'h0003e055);
    show("link hex", 4'h5, 10'h0, 16'he0aa, 3'h5, 13'h0, 8'h0, hex_exp(16'ha0aa));
    show("card segments", 4'h8, 10'h0, 16'h0, 3'h0, 13'h1a5c, 8'h3c, 32'h003c1a5c);
    show("card hex in", 4'h9, 10'h0, 16'h0, 3'h0, 13'h1a5c, 8'h3c, hex_exp(16'h1a5c));
    show("card hex out", 4'hb, 10'h0, 16'h0, 3'h0, 13'h1a5c, 8'h3c, hex_exp(16'h003c));
    // second reset in mid-run: control and display must return to their reset values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("display after second reset", 32'h0, seg);
    ahb(1'b0, 32'h0, 32'h0);
    check("control after second reset", 32'h0, q);
    ahb(1'b0, 32'hc, 32'h0);
    check("unmapped read", 32'h0, q);
    ahb(1'b1, 32'h0, 32'h0);
    @(posedge clk);
    closed <= 10'h0;
    cin <= 13'h0;
    cout <= 8'h0;
    repeat (3) @(posedge clk);
    // 24 samples span six half periods, so exactly half of them show the lit phase
    on = 0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      #1;
      if (seg === 32'h40404040) begin
        on++;
        check("idle blink digits", 32'hf, {28'h0, lit});
      end else begin
        check("idle blink shape", 32'h0, seg);
      end
    end
    check("idle blink lit count", 32'd12, 32'(on));
    report_and_stop;
  end
endmodule // terminal_status_display_encoder_tb_top
`default_nettype wire
